// ---- rtl/atg_pkg.sv ----
/*
 * Constants and carrier types for the acoustic indicator tone generator.
 * Assumes a 100 MHz system clock and a 32 kHz audio sample rate.
 */
package atg_pkg;
	// clocking and audio timing
	localparam int CLK_HZ       = 100_000_000;
	localparam int SAMPLE_HZ    = 32_000;
	localparam int DIV_CYCLES   = CLK_HZ / SAMPLE_HZ;
	localparam int FADE_MS      = 64;
	localparam int FADE_SAMPLES = FADE_MS * SAMPLE_HZ / 1000;
	localparam int FADE_SHIFT   = 11;
	// sound store geometry
	localparam int NUM_EVENTS = 10;
	localparam int NUM_COMPS  = 6;
	localparam int NUM_PURE   = 4;
	localparam int NUM_ENTRY  = NUM_EVENTS * NUM_COMPS;
	localparam int AUDIO_W    = 20;
	// register byte addresses
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_KIND   = 8'h08;
	localparam logic [7:0] ADDR_SEL    = 8'h0c;
	localparam logic [7:0] ADDR_FREQ   = 8'h10;
	localparam logic [7:0] ADDR_AMP    = 8'h14;
	localparam logic [7:0] ADDR_START  = 8'h18;
	localparam logic [7:0] ADDR_DUR    = 8'h1c;
	localparam logic [7:0] ADDR_DECAY  = 8'h20;
	localparam logic [7:0] ADDR_TRIG   = 8'h24;
	// field positions and reset values
	localparam int          CTRL_EN_BIT    = 0;
	localparam int          CTRL_ATTEN_LSB = 8;
	localparam logic [31:0] CTRL_RESET     = 32'h0000_4001;
	localparam int          SEL_COMP_LSB   = 4;
	localparam int          STAT_SOUND_LSB = 4;
	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// one stored tone component
	typedef struct packed {
		logic [15:0] freq;
		logic [15:0] amp;
		logic [15:0] start;
		logic [15:0] dur;
		logic [3:0]  decay;
	} atg_param_type;
endpackage : atg_pkg

// ---- rtl/atg_tone_gen.sv ----
/*
 * Indicator tone generator: event-selected stored sounds of pure or damped
 * tone components, mixed with attenuated program audio, AXI4-Lite registers.
 * Assumes event requests and program audio synchronous to aclk; the audio
 * sink drains one word per 32 kHz sample through a valid/ready handshake.
 */
`timescale 1ns/1ns
module atg_tone_gen
	import atg_pkg::*;
(
	// clock and reset
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	// axi4-lite write channels
	input  wire logic [7:0]                awaddr,
	input  wire logic [2:0]                awprot,
	input  wire logic                      awvalid,
	output logic                           awready,
	input  wire logic [31:0]               wdata,
	input  wire logic [3:0]                wstrb,
	input  wire logic                      wvalid,
	output logic                           wready,
	output logic [1:0]                     bresp,
	output logic                           bvalid,
	input  wire logic                      bready,
	// axi4-lite read channels
	input  wire logic [7:0]                araddr,
	input  wire logic [2:0]                arprot,
	input  wire logic                      arvalid,
	output logic                           arready,
	output logic [31:0]                    rdata,
	output logic [1:0]                     rresp,
	output logic                           rvalid,
	input  wire logic                      rready,
	// event sources and program audio
	input  wire logic [NUM_EVENTS-1:0]     event_req,
	input  wire logic signed [AUDIO_W-1:0] prog_sample,
	// mixed audio toward the signal path
	output logic                           audio_valid,
	input  wire logic                      audio_ready,
	output logic signed [AUDIO_W-1:0]      audio_data
);
	typedef enum logic [1:0] {ST_IDLE, ST_CALC, ST_PUSH} atg_state_type;

	logic [31:0]           ctrl;
	logic [NUM_EVENTS-1:0] kind;
	logic [3:0]            sel_sound;
	logic [2:0]            sel_comp;
	logic [NUM_EVENTS-1:0] sw_trig;
	atg_param_type         mem [NUM_ENTRY];
	logic                  aw_full, w_full, wr_fire;
	logic [7:0]            aw_addr;
	logic [31:0]           w_data, wr_mask, wr_val;
	logic [3:0]            w_strb;
	logic [32:0]           wr_old, rd_new;
	logic [11:0]           div_cnt;
	logic                  tick, tick_pend, start_play, start_pass;
	logic [NUM_EVENTS-1:0] trig_pend, take;
	atg_state_type         st;
	logic [2:0]            comp;
	logic                  busy, play_damped, pending;
	logic [3:0]            cur_sound;
	logic [15:0]           t;
	logic [15:0]           phase [NUM_COMPS];
	logic [15:0]           env [NUM_COMPS];
	logic signed [21:0]    acc;
	logic signed [AUDIO_W-1:0] prog_q, buf_q [2];
	logic [1:0]            cnt;
	logic                  buf_in_ready, push, pop;

	// sound/component pair to flat store index
	function automatic logic [5:0] ent(input logic [3:0] s, input logic [2:0] c);
		ent = 6'({s, 2'h0}) + 6'({s, 1'h0}) + 6'(c);
	endfunction : ent

	// register read view: {ok, value}
	function automatic logic [32:0] reg_read(input logic [7:0] a);
		atg_param_type p;
		p = (sel_sound < 4'(NUM_EVENTS) && sel_comp < 3'(NUM_COMPS)) ? mem[ent(sel_sound, sel_comp)] : '0;
		case (a)
			ADDR_CTRL:   reg_read = {1'h1, ctrl};
			ADDR_STATUS: reg_read = {1'h1, 24'h0, cur_sound, 3'h0, busy};
			ADDR_KIND:   reg_read = {1'h1, 22'h0, kind};
			ADDR_SEL:    reg_read = {1'h1, 25'h0, sel_comp, sel_sound};
			ADDR_FREQ:   reg_read = {1'h1, 16'h0, p.freq};
			ADDR_AMP:    reg_read = {1'h1, 16'h0, p.amp};
			ADDR_START:  reg_read = {1'h1, 16'h0, p.start};
			ADDR_DUR:    reg_read = {1'h1, 16'h0, p.dur};
			ADDR_DECAY:  reg_read = {1'h1, 28'h0, p.decay};
			ADDR_TRIG:   reg_read = {1'h1, 32'h0};
			default:     reg_read = {1'h0, 32'h0};
		endcase
	endfunction : reg_read

	// write side: address and data latched in either order
	assign awready = !aw_full && !bvalid;
	assign wready  = !w_full && !bvalid;
	assign wr_fire = aw_full && w_full && !bvalid;
	assign wr_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
	// process, not assign: the function reads registers that are not its arguments
	always_comb wr_old = reg_read(aw_addr);
	assign wr_val  = (wr_old[31:0] & ~wr_mask) | (w_data & wr_mask);
	always_comb rd_new = reg_read(araddr);
	assign arready = !rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full <= 1'h0;
			w_full  <= 1'h0;
			aw_addr <= 8'h0;
			w_data  <= 32'h0;
			w_strb  <= 4'h0;
			bvalid  <= 1'h0;
			bresp   <= RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_full <= 1'h1;
				aw_addr <= awaddr;
			end
			if (wvalid && wready) begin
				w_full <= 1'h1;
				w_data <= wdata;
				w_strb <= wstrb;
			end
			if (wr_fire) begin
				aw_full <= 1'h0;
				w_full  <= 1'h0;
				bvalid  <= 1'h1;
				bresp   <= wr_old[32] ? RESP_OKAY : RESP_SLVERR;
			end else if (bready) begin
				bvalid <= 1'h0;
			end
		end
	end

	// read side: one beat, answered the cycle after the address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'h0;
			rdata  <= 32'h0;
			rresp  <= RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'h1;
			rdata  <= rd_new[31:0];
			rresp  <= rd_new[32] ? RESP_OKAY : RESP_SLVERR;
		end else if (rready) begin
			rvalid <= 1'h0;
		end
	end

	// register file and per-event sound store
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl      <= CTRL_RESET;
			kind      <= '0;
			sel_sound <= 4'h0;
			sel_comp  <= 3'h0;
			sw_trig   <= '0;
			for (int i = 0; i < NUM_ENTRY; i++)
				mem[i] <= '0;
		end else begin
			sw_trig <= '0;
			if (wr_fire) begin
				case (aw_addr)
					ADDR_CTRL: ctrl <= wr_val;
					ADDR_KIND: kind <= wr_val[NUM_EVENTS-1:0];
					ADDR_SEL: begin
						sel_sound <= wr_val[3:0];
						sel_comp  <= wr_val[SEL_COMP_LSB +: 3];
					end
					ADDR_TRIG: sw_trig <= wr_val[NUM_EVENTS-1:0];
					default: ;
				endcase
				// out-of-range selections drop parameter writes
				if (sel_sound < 4'(NUM_EVENTS) && sel_comp < 3'(NUM_COMPS)) begin
					case (aw_addr)
						ADDR_FREQ:  mem[ent(sel_sound, sel_comp)].freq  <= wr_val[15:0];
						ADDR_AMP:   mem[ent(sel_sound, sel_comp)].amp   <= wr_val[15:0];
						ADDR_START: mem[ent(sel_sound, sel_comp)].start <= wr_val[15:0];
						ADDR_DUR:   mem[ent(sel_sound, sel_comp)].dur   <= wr_val[15:0];
						ADDR_DECAY: mem[ent(sel_sound, sel_comp)].decay <= wr_val[3:0];
						default: ;
					endcase
				end
			end
		end
	end

	// sample-rate enable from the system clock
	assign tick = div_cnt == 12'(DIV_CYCLES - 1);
	always_ff @(posedge aclk) begin
		if (!aresetn)
			div_cnt <= 12'h0;
		else
			div_cnt <= tick ? 12'h0 : div_cnt + 12'h1;
	end

	// lowest numbered pending event wins; others wait their turn
	always_comb begin
		take = '0;
		for (int i = NUM_EVENTS - 1; i >= 0; i--)
			if (trig_pend[i])
				take = NUM_EVENTS'(1) << i;
	end
	assign start_play = st == ST_IDLE && !busy && trig_pend != '0;
	assign start_pass = st == ST_IDLE && tick_pend && !start_play;

	// request and tick latches; a new arrival beats the clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			trig_pend <= '0;
			tick_pend <= 1'h0;
		end else begin
			trig_pend <= (trig_pend & ~(start_play ? take : '0))
				| ((event_req | sw_trig) & {NUM_EVENTS{ctrl[CTRL_EN_BIT]}});
			tick_pend <= tick || (tick_pend && !start_pass);
		end
	end

	// component evaluation for the current sound and component index
	atg_param_type      cur;
	logic [16:0]        end_t;
	logic [15:0]        local_t, remain, ramp_raw, level, damp_base;
	logic [11:0]        ramp;
	logic [27:0]        pure_prod;
	logic               comp_en, active;
	logic [13:0]        tri_mag;
	logic signed [14:0] wave;
	logic signed [31:0] prod;
	logic signed [21:0] contrib;
	assign cur       = mem[ent(cur_sound, comp)];
	assign end_t     = {1'h0, cur.start} + {1'h0, cur.dur};
	assign comp_en   = cur.dur != 16'h0 && (play_damped || comp < 3'(NUM_PURE));
	assign active    = busy && comp_en && t >= cur.start && {1'h0, t} < end_t;
	assign local_t   = t - cur.start;
	assign remain    = cur.dur - 16'h1 - local_t;
	assign ramp_raw  = local_t < remain ? local_t : remain;
	assign ramp      = ramp_raw > 16'(FADE_SAMPLES) ? 12'(FADE_SAMPLES) : ramp_raw[11:0];
	assign pure_prod = cur.amp * ramp;
	assign damp_base = local_t == 16'h0 ? cur.amp : env[comp];
	assign level     = !active ? 16'h0 : play_damped ? damp_base : 16'(pure_prod >> FADE_SHIFT);
	// triangle wave keeps the tone cheap: no table, no multiplier for sine
	assign tri_mag   = phase[comp][14] ? ~phase[comp][13:0] : phase[comp][13:0];
	assign wave      = phase[comp][15] ? 15'sd8192 - $signed({1'h0, tri_mag})
		: $signed({1'h0, tri_mag}) - 15'sd8192;
	assign prod      = wave * $signed({1'h0, level});
	assign contrib   = 22'(prod >>> 15);

	// sequencer: one component per clock, then one output word per sample
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st          <= ST_IDLE;
			comp        <= 3'h0;
			busy        <= 1'h0;
			play_damped <= 1'h0;
			cur_sound   <= 4'h0;
			t           <= 16'h0;
			pending     <= 1'h0;
			acc         <= '0;
			prog_q      <= '0;
			for (int i = 0; i < NUM_COMPS; i++) begin
				phase[i] <= 16'h0;
				env[i]   <= 16'h0;
			end
		end else begin
			case (st)
				ST_IDLE: begin
					if (start_play) begin
						busy        <= 1'h1;
						t           <= 16'h0;
						play_damped <= |(take & kind);
						for (int i = 0; i < NUM_EVENTS; i++)
							if (take[i])
								cur_sound <= 4'(i);
					end else if (start_pass) begin
						prog_q  <= prog_sample;
						acc     <= '0;
						pending <= 1'h0;
						comp    <= 3'h0;
						st      <= busy ? ST_CALC : ST_PUSH;
					end
				end
				ST_CALC: begin
					acc        <= acc + contrib;
					phase[comp] <= active ? phase[comp] + cur.freq : 16'h0;
					if (active && play_damped)
						env[comp] <= damp_base - (cur.decay == 4'h0 ? 16'h0 : damp_base >> cur.decay);
					pending <= pending || (comp_en && {1'h0, t} < end_t);
					if (comp == 3'(NUM_COMPS - 1))
						st <= ST_PUSH;
					else
						comp <= comp + 3'h1;
				end
				ST_PUSH: begin
					if (buf_in_ready) begin
						st <= ST_IDLE;
						t  <= t + 16'h1;
						if (busy && !pending)
							busy <= 1'h0;
					end
				end
				default: st <= ST_IDLE;
			endcase
		end
	end

	// program mix: attenuated under the indicator, untouched otherwise
	logic signed [28:0]        prog_prod;
	logic signed [22:0]        mix;
	logic signed [AUDIO_W-1:0] mix_sat;
	assign prog_prod = prog_q * $signed({1'h0, ctrl[CTRL_ATTEN_LSB +: 8]});
	assign mix       = busy ? 23'(acc) + 23'(prog_prod >>> 8) : 23'(prog_q);
	assign mix_sat   = mix > 23'sd524287 ? 20'sh7ffff : mix < -23'sd524288 ? 20'sh80000 : 20'(mix);

	// two-entry output buffer; a stalled sink holds the sequencer in push
	assign buf_in_ready = cnt != 2'h2;
	assign push         = st == ST_PUSH && buf_in_ready;
	assign pop          = audio_valid && audio_ready;
	assign audio_valid  = cnt != 2'h0;
	assign audio_data   = buf_q[0];
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt      <= 2'h0;
			buf_q[0] <= '0;
			buf_q[1] <= '0;
		end else begin
			if (pop)
				buf_q[0] <= buf_q[1];
			if (push)
				buf_q[1'(cnt - {1'h0, pop})] <= mix_sat;
			cnt <= cnt + {1'h0, push} - {1'h0, pop};
		end
	end

	// checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_trig_seen;
		st == ST_IDLE && !busy && trig_pend != '0;
	endsequence
	sequence s_pass_begin;
		start_pass && busy;
	endsequence
	wire in_calc = st == ST_CALC;

	a_event_start: assert property (s_trig_seen |=> busy && t == 16'h0)
		else $error("event did not start its sound");
	a_kind_hold: assert property (busy && $past(busy) |-> $stable(play_damped) && $stable(cur_sound))
		else $error("sound kind changed mid play");
	a_pure_limit: assert property (in_calc && !play_damped && comp >= 3'(NUM_PURE) |-> level == 16'h0)
		else $error("pure sound used a fifth component");
	a_fade_edges: assert property (in_calc && !play_damped && active && local_t == 16'h0 |-> level == 16'h0)
		else $error("fade-in did not start from silence");
	a_start_gate: assert property (in_calc && t < cur.start |-> level == 16'h0)
		else $error("component sounded before its start");
	a_dur_end: assert property (in_calc && {1'h0, t} >= end_t |-> level == 16'h0)
		else $error("component sounded past its duration");
	a_damp_bound: assert property (in_calc && play_damped && active |-> level <= cur.amp)
		else $error("damped level above amplitude");
	a_damp_onset: assert property (in_calc && play_damped && active && local_t == 16'h0 |-> level == cur.amp)
		else $error("damped onset not at full amplitude");
	a_mix_atten: assert property (st == ST_PUSH && busy && acc == '0 |-> mix == 23'(prog_prod >>> 8))
		else $error("program not attenuated under indicator");
	a_pass_seq: assert property (s_pass_begin |=> in_calc && comp == 3'h0 ##6 st == ST_PUSH)
		else $error("sample pass did not visit six components");
	a_silence: assert property (push && busy && !pending |=> !busy)
		else $error("sound did not end after last component");
endmodule : atg_tone_gen

// ---- dv/atg_audio_sink.sv ----
/*
 * Audio path model for the indicator tone generator: drains mixed words.
 * Assumes one clock; after each word it stalls 40 cycles so the block must
 * hold a waiting word steady in its two-entry buffer.
 */
`timescale 1ns/1ns
module atg_audio_sink
	import atg_pkg::*;
(
	// clock and reset
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	// mixed audio from the block
	input  wire logic                      audio_valid,
	input  wire logic signed [AUDIO_W-1:0] audio_data,
	output logic                           audio_ready,
	// observation toward the bench
	output logic                           got,
	output logic signed [AUDIO_W-1:0]      word,
	output logic                           hold_err
);
	logic [5:0]                stall;
	logic                      pend;
	logic signed [AUDIO_W-1:0] held;

	// slow acceptance, still far quicker than one sample tick
	assign audio_ready = aresetn && (stall == 6'h00);

	// take a word, then stall
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stall <= 6'h00;
			got   <= 1'b0;
			word  <= '0;
		end else begin
			got <= audio_valid && audio_ready;
			if (audio_valid && audio_ready) begin
				word  <= audio_data;
				stall <= 6'h28;
			end else if (stall != 6'h00) begin
				stall <= stall - 6'h01;
			end
		end
	end

	// a refused word must not change while it waits
	always_ff @(posedge aclk) begin
		pend <= aresetn && audio_valid && !audio_ready;
		held <= audio_data;
		if (!aresetn) begin
			hold_err <= 1'b0;
		end else if (pend && audio_valid && (audio_data !== held)) begin
			hold_err <= 1'b1;
		end
	end
endmodule : atg_audio_sink

// ---- dv/acoustic_indicator_tone_gen_tb.sv ----
/*
 * Self-checking bench for the indicator tone generator: register access,
 * program pass-through, attenuation and pure and damped sounds.
 * Assumes the audio sink model in atg_audio_sink and a 100 MHz clock.
 */
`timescale 1ns/1ns
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin mismatches++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module acoustic_indicator_tone_gen_tb;
	import atg_pkg::*;
	logic                      aclk = 1'b0;
	logic                      aresetn = 1'b0;
	logic [7:0]                awaddr = 8'h00;
	logic [7:0]                araddr = 8'h00;
	logic [31:0]               wdata = 32'h0;
	logic                      awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic                      awready, wready, bvalid, arready, rvalid, audio_valid, audio_ready;
	logic [1:0]                bresp, rresp, r;
	logic [31:0]               rdata, d;
	logic [NUM_EVENTS-1:0]     event_req = '0;
	logic signed [AUDIO_W-1:0] prog_sample = '0;
	logic signed [AUDIO_W-1:0] audio_data, word, w;
	logic                      got, hold_err;
	int                        mismatches = 0, check_count = 0, dev, cyc;
	time                       t0;

	// 100 MHz clock
	always #5 aclk = ~aclk;

	atg_tone_gen dut (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb(4'hf),
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .event_req, .prog_sample, .audio_valid, .audio_ready, .audio_data);
	atg_audio_sink sink (.aclk, .aresetn, .audio_valid, .audio_data, .audio_ready, .got, .word, .hold_err);

	task automatic results();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : results

	// write: address and data offered together; bready stays high between calls,
	// so a call right after another never drives it twice in one step
	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		awaddr  <= a;
		wdata   <= v;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!(bvalid && bready));
		rs = bresp;
	endtask : wr

	// read: no cycle limit of its own, only the watchdog ends a wait
	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!(rvalid && rready));
		v = rdata;
		rs = rresp;
	endtask : rd

	// bounded wait for the next word taken by the sink
	task automatic next_word(output logic signed [AUDIO_W-1:0] o);
		int n;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (!got && n < 5000);
		if (!got) mismatches++;
		o = word;
	endtask : next_word

	task automatic cfg(input int s, input int c, input logic [15:0] f, input logic [15:0] a,
		input logic [15:0] st, input logic [15:0] du, input logic [3:0] k);
		wr(ADDR_SEL, 32'(c * 16 + s), r);
		wr(ADDR_FREQ, {16'h0, f}, r);
		wr(ADDR_AMP, {16'h0, a}, r);
		wr(ADDR_START, {16'h0, st}, r);
		wr(ADDR_DUR, {16'h0, du}, r);
		wr(ADDR_DECAY, {28'h0, k}, r);
	endtask : cfg

	// start a sound, then largest distance from rf over its words (first skipped)
	task automatic play(input int ev, input logic pin, input int rf, output int md);
		int n;
		int v;
		if (pin) begin
			event_req[ev] <= 1'b1;
			@(posedge aclk);
			event_req[ev] <= 1'b0;
		end else begin
			wr(ADDR_TRIG, 32'h1 << ev, r);
		end
		n = 0;
		do begin
			rd(ADDR_STATUS, d, r);
			n++;
		end while (!d[0] && n < 20);
		`CHK(d[7:4], 4'(ev))
		md = 0;
		n = 0;
		do begin
			next_word(w);
			v = int'(w) - rf;
			if (v < 0) v = -v;
			if (n > 0 && v > md) md = v;
			rd(ADDR_STATUS, d, r);
			n++;
		end while (d[0] && n < 30);
		`CHK(d[0], 1'b0)
	endtask : play

	// hang guard: the run needs about 72k cycles, mostly waiting on sample ticks
	initial begin
		repeat (95000) @(posedge aclk);
		mismatches++;
		results();
	end

	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(ADDR_CTRL, d, r);
		`CHK(d, CTRL_RESET)
		rd(ADDR_STATUS, d, r);
		`CHK(d, 32'h0)
		wr(ADDR_KIND, 32'hffff_ffff, r);
		rd(ADDR_KIND, d, r);
		`CHK(d, 32'h0000_03ff)
		rd(ADDR_TRIG, d, r);
		`CHK(d, 32'h0)
		rd(8'h40, d, r);
		`CHK({r, d}, {RESP_SLVERR, 32'h0})
		wr(8'h44, 32'h1, r);
		`CHK(r, RESP_SLVERR)
		// idle: program passes at unity, one word per tick
		prog_sample <= 20'sh12345;
		next_word(w);
		next_word(w);
		t0 = $time;
		next_word(w);
		cyc = int'(($time - t0) / 10);
		`CHK(w, 20'sh12345)
		`CHK(cyc, DIV_CYCLES)
		// event 0 silent pure, event 6 pure, event 9 damped
		wr(ADDR_KIND, 32'h0000_0200, r);
		cfg(0, 0, 16'h4000, 16'h0000, 16'h0000, 16'h0004, 4'h0);
		cfg(6, 0, 16'h4000, 16'h7fff, 16'h0000, 16'h0006, 4'h0);
		cfg(6, 4, 16'h4000, 16'h7fff, 16'h0000, 16'h0006, 4'h0);
		cfg(9, 5, 16'h4000, 16'h4000, 16'h0002, 16'h0003, 4'h1);
		rd(ADDR_AMP, d, r);
		`CHK(d, 32'h0000_4000)
		// disabled: an event is not latched
		wr(ADDR_CTRL, 32'h0000_4000, r);
		event_req[3] <= 1'b1;
		@(posedge aclk);
		event_req[3] <= 1'b0;
		repeat (8) @(posedge aclk);
		rd(ADDR_STATUS, d, r);
		`CHK(d[0], 1'b0)
		wr(ADDR_CTRL, CTRL_RESET, r);
		// attenuation 0x40/256 under a silent sound, unity once it ends
		prog_sample <= 20'sh01000;
		play(0, 1'b0, 'h400, dev);
		`CHK(dev, 0)
		next_word(w);
		next_word(w);
		`CHK(w, 20'sh01000)
		// pure: a 6-sample ramp peaks near amp/1024, so one tone stays under 16;
		// a second, illegal fifth component would double it
		prog_sample <= '0;
		play(6, 1'b1, 0, dev);
		`CHK(dev > 0 && dev < 32'h10, 1'b1)
		// damped: full amplitude at once on component 5
		play(9, 1'b0, 0, dev);
		`CHK(dev >= 'h1000, 1'b1)
		`CHK(hold_err, 1'b0)
		results();
	end
endmodule : acoustic_indicator_tone_gen_tb
